// file: rtl/hdlsr_link_receiver.sv
// data link position select, three receive link controllers and host registers
// Notes on behaviour
// - path-select bit clear: position registers address the receive bank.
// - path-select bit set: position registers address the transmit bank.
// - receive selector bits 7:6, code 00 link 1, 01 link 2.
// - transmit selector bits 5:4, code 00 link 1.
// - position: even bit 7, odd bit 6, slot bits 4:0, mask register next.
// - link 1 positions at 028/029, link 2 at 02a/02b.
// - slot-16 enable with both parity bits clear takes all of slot 16.
// - odd-only, slot 0, mask 01 takes Sa8 of odd frames.
// - both parity bits, slot 20, mask ff takes all of slot 20.
// - transmit odd-only slot 0 mask 1f marks Sa4 to Sa8.
// - receive link works only while its enable bit is set.
// - match enable and mode bits choose address filtering on first byte.
// - primary and secondary match values at 04c and 04d.
// - fill above seven-bit threshold sets the receive flag.
// - receive flag holds until the fifo is read empty.
// - interrupt enable bit gates the flag onto the interrupt output.
// - control value 50 selects receive link 2 on the receive path.
`timescale 1ns/1ps
module hdlsr_link_receiver #(
  parameter int LINKS = hdlsr_pkg::N_LINKS,
  parameter int DEPTH = hdlsr_pkg::FIFO_DEPTH
) (
  input wire logic core_clk, // 25 MHz clock
  input wire logic sys_rst, // sync reset, high
  input wire logic clkEn, // freezes all state when low, except the clear of a disabled link
  input wire logic [hdlsr_pkg::ADDR_W-1:0] regAddr, // register address
  input wire logic regWrStb, // write strobe
  input wire logic [hdlsr_pkg::DATA_W-1:0] regWrData, // write data
  input wire logic regRdStb, // read strobe
  output logic [hdlsr_pkg::DATA_W-1:0] regRdData, // read data, next cycle
  input wire logic rxLineBit, // received line bit
  input wire logic rxBitStb, // one per received bit
  input wire logic [hdlsr_pkg::SLOT_W-1:0] rxSlot, // receive timeslot
  input wire logic [hdlsr_pkg::BITIDX_W-1:0] rxBitIdx, // 0 is first bit
  input wire logic rxOddFrame, // receive frame parity
  input wire logic txBitStb, // one per transmit bit
  input wire logic [hdlsr_pkg::SLOT_W-1:0] txSlot, // transmit timeslot
  input wire logic [hdlsr_pkg::BITIDX_W-1:0] txBitIdx, // 0 is first bit
  input wire logic txOddFrame, // transmit frame parity
  output logic [LINKS-1:0] txLinkHit, // bit belongs to tx link
  output logic [1:0] txCtlSel, // tx controller for host access
  output logic rxIrqReq // interrupt request, high
);
  import hdlsr_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int ENT_W = DATA_W + 1;

  // ----------------------------------------
  // position match
  // ----------------------------------------
  // mask bit 0 is the last bit of the slot
  function automatic logic pos_hit(input logic [DATA_W-1:0] slotReg, input logic [DATA_W-1:0] maskReg,
                                   input logic [SLOT_W-1:0] slot, input logic [BITIDX_W-1:0] bitIdx,
                                   input logic odd);
    logic frameOk;
    logic bitSel;
    frameOk = (slotReg[POS_ODD_BIT] && odd) || (slotReg[POS_EVEN_BIT] && !odd);
    bitSel = maskReg[LAST_BIT - bitIdx];
    if (slotReg[POS_TS16_BIT] && !slotReg[POS_ODD_BIT] && !slotReg[POS_EVEN_BIT]) begin
      pos_hit = (slot == SLOT_SIXTEEN);
    end else begin
      pos_hit = frameOk && (slot == slotReg[POS_SLOT_HI:0]) && bitSel;
    end
  endfunction

  // ----------------------------------------
  // control register and selectors
  // ----------------------------------------
  logic [DATA_W-1:0] linkCtlQ;
  wire pathTx = linkCtlQ[CTL_PATH_BIT];
  wire [1:0] rxSel = linkCtlQ[CTL_RXSEL_LO+1:CTL_RXSEL_LO];
  wire rxSelOk = (rxSel != SEL_NONE) && (32'(rxSel) < LINKS);
  wire wrCtl = regWrStb && (regAddr == REG_LINK_CTL);
  wire rdPop = regRdStb && (regAddr == REG_RX_DATA) && rxSelOk;
  wire rdSts = regRdStb && (regAddr == REG_RX_STS) && rxSelOk;

  // control register and tx selector output
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      linkCtlQ <= REG_RESET;
      txCtlSel <= 2'h0;
    end else if (clkEn) begin
      if (wrCtl) begin
        linkCtlQ <= regWrData;
      end
      txCtlSel <= linkCtlQ[CTL_TXSEL_LO+1:CTL_TXSEL_LO];
    end
  end

  // per-link views for the read mux and interrupt
  logic [DATA_W-1:0] posSlotW [LINKS];
  logic [DATA_W-1:0] posMaskW [LINKS];
  logic [DATA_W-1:0] cfgW [LINKS];
  logic [DATA_W-1:0] thrW [LINKS];
  logic [DATA_W-1:0] priW [LINKS];
  logic [DATA_W-1:0] secW [LINKS];
  logic [DATA_W-1:0] stsW [LINKS];
  logic [DATA_W-1:0] headW [LINKS];
  logic [LINKS-1:0] irqW;
  logic [LINKS-1:0] txHitW;

  genvar gi;
  generate
    for (gi = 0; gi < LINKS; gi++) begin : gLink
      localparam logic [ADDR_W-1:0] SLOT_A = (gi == 0) ? REG_LINK1_SLOT : (gi == 1) ? REG_LINK2_SLOT : REG_LINK3_SLOT;
      localparam logic [ADDR_W-1:0] MASK_A = (gi == 0) ? REG_LINK1_MASK : (gi == 1) ? REG_LINK2_MASK : REG_LINK3_MASK;
      localparam logic [1:0] MY_SEL = 2'(gi);
      logic [DATA_W-1:0] rxSlotQ, rxMaskQ, txSlotQ, txMaskQ;
      logic [DATA_W-1:0] cfgQ, thrQ, priQ, secQ;
      logic [DATA_W-1:0] shiftQ, pendQ;
      logic [2:0] onesQ, bitCntQ;
      logic pendVQ, flagQ, ovfQ;
      hdlsr_rx_state_t stQ;
      logic [ENT_W-1:0] buf0Q, buf1Q;
      logic buf0VQ, buf1VQ;
      logic [ENT_W-1:0] memQ [DEPTH];
      logic [PTR_W-1:0] wrPtrQ, rdPtrQ;
      logic [CNT_W-1:0] cntQ;

      // register decode for this link
      wire mine = rxSelOk && (rxSel == MY_SEL);
      wire wrSlot = regWrStb && (regAddr == SLOT_A);
      wire wrMask = regWrStb && (regAddr == MASK_A);
      wire wrCfg = regWrStb && mine && (regAddr == REG_RX_CFG);
      wire wrThr = regWrStb && mine && (regAddr == REG_RX_THR);
      wire wrPri = regWrStb && mine && (regAddr == REG_RX_PRI);
      wire wrSec = regWrStb && mine && (regAddr == REG_RX_SEC);
      wire enable = cfgQ[CFG_EN_BIT];
      wire popHere = rdPop && mine;

      // position registers, banked by the path-select bit
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          rxSlotQ <= REG_RESET;
          rxMaskQ <= REG_RESET;
          txSlotQ <= REG_RESET;
          txMaskQ <= REG_RESET;
        end else if (clkEn) begin
          if (wrSlot && !pathTx) rxSlotQ <= regWrData;
          if (wrMask && !pathTx) rxMaskQ <= regWrData;
          if (wrSlot && pathTx) txSlotQ <= regWrData;
          if (wrMask && pathTx) txMaskQ <= regWrData;
        end
      end

      // receive configuration registers
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          cfgQ <= REG_RESET;
          thrQ <= REG_RESET;
          priQ <= REG_RESET;
          secQ <= REG_RESET;
        end else if (clkEn) begin
          if (wrCfg) cfgQ <= regWrData;
          if (wrThr) thrQ <= regWrData;
          if (wrPri) priQ <= regWrData;
          if (wrSec) secQ <= regWrData;
        end
      end

      // bit extraction and hdlc decode
      wire linkBit = rxBitStb && enable && pos_hit(rxSlotQ, rxMaskQ, rxSlot, rxBitIdx, rxOddFrame);
      wire isFlag = linkBit && !rxLineBit && (onesQ == ONES_FLAG);
      wire isAbort = linkBit && rxLineBit && (onesQ == ONES_FLAG);
      wire isStuff = linkBit && !rxLineBit && (onesQ == ONES_STUFF);
      wire dataBit = linkBit && !isFlag && !isAbort && !isStuff;
      wire byteDone = dataBit && (bitCntQ == LAST_BIT);
      wire [DATA_W-1:0] newByte = {rxLineBit, shiftQ[DATA_W-1:1]};
      wire addrOk = !cfgQ[CFG_MEN_BIT] || (newByte == priQ) ||
                    (!cfgQ[CFG_MODE_BIT] && (newByte == secQ));
      wire inFrame = (stQ == RX_ADDR) || (stQ == RX_DATA);
      wire pushV = pendVQ && ((byteDone && (stQ == RX_DATA)) || (isFlag && (stQ == RX_DATA)));
      wire [ENT_W-1:0] pushE = {isFlag, pendQ};
      wire bufRdy = !buf1VQ || fifoWr;
      wire fifoFull = (cntQ == CNT_W'(DEPTH));
      wire fifoWr = buf0VQ && !fifoFull;

      // frame state and byte assembly
      always_ff @(posedge core_clk) begin
        if (sys_rst || !enable) begin
          stQ <= RX_HUNT;
          onesQ <= 3'h0;
          bitCntQ <= 3'h0;
          shiftQ <= REG_RESET;
          pendQ <= REG_RESET;
          pendVQ <= 1'b0;
        end else if (clkEn && linkBit) begin
          onesQ <= rxLineBit ? ((onesQ == ONES_FLAG) ? 3'h0 : onesQ + 3'h1) : 3'h0;
          if (dataBit) begin
            shiftQ <= newByte;
            bitCntQ <= bitCntQ + 3'h1;
          end
          if (isFlag || isAbort) begin
            bitCntQ <= 3'h0;
            pendVQ <= 1'b0;
          end
          case (stQ)
            RX_HUNT: begin
              if (isFlag) stQ <= RX_ADDR;
            end
            RX_ADDR: begin
              if (isAbort) begin
                stQ <= RX_HUNT;
              end else if (byteDone) begin
                stQ <= addrOk ? RX_DATA : RX_DROP;
                pendQ <= newByte;
                pendVQ <= addrOk;
              end
            end
            RX_DATA: begin
              if (isAbort) begin
                stQ <= RX_HUNT;
              end else if (isFlag) begin
                stQ <= RX_ADDR;
              end else if (byteDone) begin
                pendQ <= newByte;
                pendVQ <= 1'b1;
              end
            end
            RX_DROP: begin
              if (isFlag) stQ <= RX_ADDR;
              else if (isAbort) stQ <= RX_HUNT;
            end
            default: stQ <= RX_HUNT;
          endcase
        end
      end

      // two-entry buffer ahead of the fifo; full buffer drops the byte
      always_ff @(posedge core_clk) begin
        if (sys_rst || !enable) begin
          buf0Q <= '0;
          buf1Q <= '0;
          buf0VQ <= 1'b0;
          buf1VQ <= 1'b0;
        end else if (clkEn) begin
          if (fifoWr) begin
            buf0Q <= buf1VQ ? buf1Q : pushE;
            buf0VQ <= buf1VQ || (pushV && bufRdy);
            buf1Q <= pushE;
            buf1VQ <= buf1VQ && pushV;
          end else if (pushV && bufRdy) begin
            if (buf0VQ) begin
              buf1Q <= pushE;
              buf1VQ <= 1'b1;
            end else begin
              buf0Q <= pushE;
              buf0VQ <= 1'b1;
            end
          end
        end
      end

      // receive fifo storage
      always_ff @(posedge core_clk) begin
        if (clkEn && fifoWr) begin
          memQ[wrPtrQ] <= buf0Q;
        end
      end

      // fifo pointers, fill count and threshold flag
      always_ff @(posedge core_clk) begin
        if (sys_rst || !enable) begin
          wrPtrQ <= '0;
          rdPtrQ <= '0;
          cntQ <= '0;
          flagQ <= 1'b0;
        end else if (clkEn) begin
          if (fifoWr) wrPtrQ <= wrPtrQ + PTR_W'(1);
          if (popHere && cntQ != '0) rdPtrQ <= rdPtrQ + PTR_W'(1);
          cntQ <= cntQ + CNT_W'(fifoWr) - CNT_W'(popHere && cntQ != '0);
          if (cntQ > CNT_W'(thrQ[THR_HI:0])) flagQ <= 1'b1;
          else if (cntQ == '0) flagQ <= 1'b0;
        end
      end

      // overflow is sticky; a new loss wins over the status-read clear
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          ovfQ <= 1'b0;
        end else if (clkEn) begin
          if (pushV && !bufRdy) ovfQ <= 1'b1;
          else if (rdSts && mine) ovfQ <= 1'b0;
        end
      end

      // transmit position hit
      assign txHitW[gi] = txBitStb && pos_hit(txSlotQ, txMaskQ, txSlot, txBitIdx, txOddFrame);
      assign posSlotW[gi] = pathTx ? txSlotQ : rxSlotQ;
      assign posMaskW[gi] = pathTx ? txMaskQ : rxMaskQ;
      assign cfgW[gi] = cfgQ;
      assign thrW[gi] = thrQ;
      assign priW[gi] = priQ;
      assign secW[gi] = secQ;
      assign headW[gi] = memQ[rdPtrQ][DATA_W-1:0];
      assign stsW[gi] = {4'h0, memQ[rdPtrQ][DATA_W] && (cntQ != '0), ovfQ, cntQ == '0, flagQ};
      assign irqW[gi] = flagQ && thrQ[THR_IE_BIT];

      // ----------------------------------------
      // checks
      // ----------------------------------------
      flag_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && enable && cntQ > CNT_W'(thrQ[THR_HI:0]) |=> flagQ)
        else $error("fill above threshold did not raise flag");
      flag_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && enable && flagQ && cntQ > CNT_W'(1) |=> flagQ)
        else $error("flag dropped before fifo was empty");
      pop_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && enable && popHere && !fifoWr && cntQ != '0 |=> cntQ == $past(cntQ) - CNT_W'(1))
        else $error("data read did not lower fill by one");
      fifo_cap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        cntQ <= CNT_W'(DEPTH) && !(fifoFull && fifoWr))
        else $error("fifo beyond its depth");
      link_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !enable |-> !linkBit && !pushV)
        else $error("disabled link took a bit");
    end
  endgenerate

  // ----------------------------------------
  // read mux and outputs
  // ----------------------------------------
  wire [DATA_W-1:0] posRd =
    (regAddr == REG_LINK1_SLOT) ? posSlotW[0] :
    (regAddr == REG_LINK1_MASK) ? posMaskW[0] :
    (regAddr == REG_LINK2_SLOT && LINKS > 1) ? posSlotW[1 % LINKS] :
    (regAddr == REG_LINK2_MASK && LINKS > 1) ? posMaskW[1 % LINKS] :
    (regAddr == REG_LINK3_SLOT && LINKS > 2) ? posSlotW[2 % LINKS] :
    (regAddr == REG_LINK3_MASK && LINKS > 2) ? posMaskW[2 % LINKS] : REG_RESET;
  wire [1:0] selIdx = rxSelOk ? rxSel : 2'h0;
  wire [DATA_W-1:0] linkRd =
    !rxSelOk ? REG_RESET :
    (regAddr == REG_RX_CFG) ? cfgW[selIdx] :
    (regAddr == REG_RX_THR) ? thrW[selIdx] :
    (regAddr == REG_RX_STS) ? stsW[selIdx] :
    (regAddr == REG_RX_DATA) ? headW[selIdx] :
    (regAddr == REG_RX_PRI) ? priW[selIdx] :
    (regAddr == REG_RX_SEC) ? secW[selIdx] : REG_RESET;
  wire [DATA_W-1:0] rdMux = (regAddr == REG_LINK_CTL) ? linkCtlQ : (posRd | linkRd);

  // registered read data, tx hits and interrupt
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdData <= REG_RESET;
      txLinkHit <= '0;
      rxIrqReq <= 1'b0;
    end else if (clkEn) begin
      if (regRdStb) regRdData <= rdMux;
      txLinkHit <= txHitW;
      rxIrqReq <= |irqW;
    end
  end

  // ----------------------------------------
  // checks on shared logic
  // ----------------------------------------
  irq_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && !(|irqW) |=> !rxIrqReq)
    else $error("interrupt driven while gated off");
  sel_two_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && regRdStb && regAddr == REG_RX_THR && linkCtlQ == 8'h50 |=> regRdData == $past(thrW[1 % LINKS]))
    else $error("control value 50 did not select receive link 2");
  ts_sixteen_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && txBitStb && txSlot == SLOT_SIXTEEN && gLink[0].txSlotQ[POS_TS16_BIT] &&
    gLink[0].txSlotQ[POS_EVEN_BIT:POS_ODD_BIT] == 2'h0 |=> txLinkHit[0])
    else $error("slot 16 bit not marked for link 1");
  sa_eight_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    gLink[0].enable && rxBitStb && rxOddFrame && rxSlot == 5'h00 && rxBitIdx == LAST_BIT &&
    gLink[0].rxSlotQ == 8'h40 && gLink[0].rxMaskQ == 8'h01 |-> gLink[0].linkBit)
    else $error("sa8 of odd frame not extracted");
  ts_twenty_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    gLink[0].enable && rxBitStb && rxSlot == 5'h14 && gLink[0].rxSlotQ == 8'hd4 &&
    gLink[0].rxMaskQ == 8'hff |-> gLink[0].linkBit)
    else $error("slot 20 bit not extracted");
endmodule

// file: rtl/hdlsr_pkg.sv
// constants, register map and types for the link select and receive block
package hdlsr_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int N_LINKS = 3;
  localparam int FIFO_DEPTH = 128;
  localparam int SLOT_W = 5;
  localparam int BITIDX_W = 3;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_LINK_CTL = 10'h00a;
  localparam logic [ADDR_W-1:0] REG_LINK1_SLOT = 10'h028;
  localparam logic [ADDR_W-1:0] REG_LINK1_MASK = 10'h029;
  localparam logic [ADDR_W-1:0] REG_LINK2_SLOT = 10'h02a;
  localparam logic [ADDR_W-1:0] REG_LINK2_MASK = 10'h02b;
  localparam logic [ADDR_W-1:0] REG_LINK3_SLOT = 10'h02c;
  localparam logic [ADDR_W-1:0] REG_LINK3_MASK = 10'h02d;
  localparam logic [ADDR_W-1:0] REG_RX_CFG = 10'h048;
  localparam logic [ADDR_W-1:0] REG_RX_THR = 10'h049;
  localparam logic [ADDR_W-1:0] REG_RX_STS = 10'h04a;
  localparam logic [ADDR_W-1:0] REG_RX_DATA = 10'h04b;
  localparam logic [ADDR_W-1:0] REG_RX_PRI = 10'h04c;
  localparam logic [ADDR_W-1:0] REG_RX_SEC = 10'h04d;
  // ----------------------------------------
  // field positions and codes
  // ----------------------------------------
  localparam int CTL_PATH_BIT = 3;
  localparam int CTL_RXSEL_LO = 6;
  localparam int CTL_TXSEL_LO = 4;
  localparam int POS_EVEN_BIT = 7;
  localparam int POS_ODD_BIT = 6;
  localparam int POS_TS16_BIT = 5;
  localparam int POS_SLOT_HI = 4;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_MODE_BIT = 2;
  localparam int CFG_MEN_BIT = 3;
  localparam int THR_IE_BIT = 7;
  localparam int THR_HI = 6;
  localparam int STS_FLAG_BIT = 0;
  localparam int STS_EMPTY_BIT = 1;
  localparam int STS_OVF_BIT = 2;
  localparam int STS_EOP_BIT = 3;
  localparam logic [1:0] SEL_NONE = 2'h3;
  localparam logic [SLOT_W-1:0] SLOT_SIXTEEN = 5'h10;
  localparam logic [BITIDX_W-1:0] LAST_BIT = 3'h7;
  localparam logic [2:0] ONES_STUFF = 3'h5;
  localparam logic [2:0] ONES_FLAG = 3'h6;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // receive frame states
  // ----------------------------------------
  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_ADDR = 4'b0010,
    RX_DATA = 4'b0100,
    RX_DROP = 4'b1000
  } hdlsr_rx_state_t;
endpackage

// file: tb/hdlsr_line_model.sv
// line side bit stream model feeding one data link position
`timescale 1ns/1ps
module hdlsr_line_model #(
  parameter logic [7:0] POS_CFG = 8'hd4,
  parameter logic [7:0] POS_MASK = 8'hff
) (
  input wire logic core_clk, // bench clock
  input wire logic sys_rst, // sync reset, high
  output logic lineBit, // serial line bit
  output logic bitStb, // one per bit
  output logic [4:0] slot, // timeslot
  output logic [2:0] bitIdx, // bit within slot
  output logic oddFrame, // frame parity
  output logic idle // nothing left queued
);
  logic phase;
  logic [8:0] pos;
  logic hit;
  bit q[$];
  int ones = 0;
  // --------------------------------
  // position decode of the served link
  // --------------------------------
  assign {oddFrame, slot, bitIdx} = pos;
  assign hit = (oddFrame ? POS_CFG[6] : POS_CFG[7]) && slot == POS_CFG[4:0] && POS_MASK[7 - bitIdx];
  // one bit every second cycle; off position the line toggles so no stale value survives
  always @(posedge core_clk) begin
    if (sys_rst) begin
      phase <= 1'b0;
      pos <= '0;
      bitStb <= 1'b0;
      lineBit <= 1'b1;
    end else begin
      phase <= ~phase;
      bitStb <= ~phase;
      if (phase)
        pos <= pos + 9'h001;
      else if (hit && q.size() > 0)
        lineBit <= q.pop_front();
      else
        lineBit <= hit | ~lineBit;
    end
    idle <= (q.size() == 0);
  end
  // --------------------------------
  // byte queueing, lsb first, zero stuffed after five ones
  // --------------------------------
  task automatic sendByte(input logic [7:0] b, input bit flag);
    for (int i = 0; i < 8; i++) begin
      q.push_back(b[i]);
      ones = (b[i] && !flag) ? ones + 1 : 0;
      if (ones == 5) begin
        q.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the link select and receive block
`timescale 1ns/1ps
module tb;
  import hdlsr_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData;
  logic lineBit, bitStb, oddFrame, idle, rxIrqReq;
  logic [4:0] slot;
  logic [2:0] bitIdx;
  logic [2:0] txLinkHit;
  logic [1:0] txCtlSel;
  logic [7:0] rdv;
  int nMismatch = 0;
  int numChecks = 0;
  int hitCnt = 0;
  // --------------------------------
  // clock, instances, tx hit counter
  // --------------------------------
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  hdlsr_link_receiver i_hdlsr_link_receiver (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1),
    .regAddr(regAddr), .regWrStb(regWrStb), .regWrData(regWrData), .regRdStb(regRdStb),
    .regRdData(regRdData), .rxLineBit(lineBit), .rxBitStb(bitStb), .rxSlot(slot), .rxBitIdx(bitIdx),
    .rxOddFrame(oddFrame), .txBitStb(bitStb), .txSlot(slot), .txBitIdx(bitIdx), .txOddFrame(oddFrame),
    .txLinkHit(txLinkHit), .txCtlSel(txCtlSel), .rxIrqReq(rxIrqReq));
  hdlsr_line_model i_hdlsr_line_model (.core_clk(core_clk), .sys_rst(sys_rst), .lineBit(lineBit),
    .bitStb(bitStb), .slot(slot), .bitIdx(bitIdx), .oddFrame(oddFrame), .idle(idle));
  always @(posedge core_clk) begin
    if (txLinkHit[0])
      hitCnt <= hitCnt + 1;
  end
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic testDone();
    if (nMismatch == 0 && numChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge core_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 rdv = regRdData;
    chk(rdv & m, e);
  endtask
  task automatic frm(input logic [7:0] d[$]);
    i_hdlsr_line_model.sendByte(8'h7e, 1'b1);
    foreach (d[i]) i_hdlsr_line_model.sendByte(d[i], 1'b0);
    i_hdlsr_line_model.sendByte(8'h7e, 1'b1);
  endtask
  task automatic waitIdle();
    int n = 0;
    cyc(2);
    while (idle !== 1'b1 && n < 30000) begin
      @(posedge core_clk);
      n++;
    end
    if (idle !== 1'b1) begin
      nMismatch++;
      testDone();
    end
    cyc(60);
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic tReset();
    logic [ADDR_W-1:0] al[7];
    al = '{REG_LINK_CTL, REG_LINK1_SLOT, REG_LINK1_MASK, REG_RX_CFG, REG_RX_THR, REG_RX_PRI, 10'h3ff};
    wr(10'h3ff, 8'h5a);
    foreach (al[i]) rc(al[i], 8'h00, 8'hff);
    chk({7'h0, rxIrqReq}, 8'h00);
  endtask
  task automatic tRx();
    logic [7:0] exp[4] = '{8'h13, 8'h12, 8'h34, 8'h56};
    wr(REG_LINK_CTL, 8'h50);
    rc(REG_LINK_CTL, 8'h50, 8'hff);
    chk({6'h0, txCtlSel}, 8'h01);
    wr(REG_LINK2_SLOT, 8'hd4);
    wr(REG_LINK2_MASK, 8'hff);
    rc(REG_LINK2_SLOT, 8'hd4, 8'hff);
    frm('{8'h13, 8'h12});
    waitIdle();
    rc(REG_RX_STS, 8'h02, 8'h0f);
    wr(REG_RX_CFG, 8'h0d);
    wr(REG_RX_THR, 8'h82);
    wr(REG_RX_PRI, 8'h13);
    wr(REG_RX_SEC, 8'hff);
    rc(REG_RX_SEC, 8'hff, 8'hff);
    rc(REG_RX_THR, 8'h82, 8'hff);
    frm('{8'hff, 8'h11});
    frm('{8'h13, 8'h12, 8'h34, 8'h56});
    waitIdle();
    chk({7'h0, rxIrqReq}, 8'h01);
    rc(REG_RX_STS, 8'h01, 8'h03);
    wr(REG_RX_THR, 8'h02);
    cyc(3);
    chk({7'h0, rxIrqReq}, 8'h00);
    wr(REG_RX_THR, 8'h82);
    cyc(3);
    chk({7'h0, rxIrqReq}, 8'h01);
    foreach (exp[i]) begin
      if (i == 3)
        rc(REG_RX_STS, 8'h09, 8'h0f);
      rc(REG_RX_DATA, exp[i], 8'hff);
    end
    rc(REG_RX_STS, 8'h02, 8'h03);
    cyc(2);
    chk({7'h0, rxIrqReq}, 8'h00);
  endtask
  task automatic tTx();
    logic [7:0] cfg[4] = '{8'h20, 8'h40, 8'hd4, 8'h40};
    logic [7:0] msk[4] = '{8'h00, 8'h01, 8'hff, 8'h1f};
    logic [7:0] want[4] = '{8'h10, 8'h01, 8'h10, 8'h05};
    wr(REG_LINK_CTL, 8'h08);
    cyc(2);
    chk({6'h0, txCtlSel}, 8'h00);
    foreach (cfg[i]) begin
      wr(REG_LINK1_SLOT, cfg[i]);
      wr(REG_LINK1_MASK, msk[i]);
      cyc(4);
      #1 hitCnt = 0;
      cyc(1024);
      #1 chk(hitCnt[7:0], want[i]);
    end
    rc(REG_LINK1_SLOT, 8'h40, 8'hff);
    wr(REG_LINK_CTL, 8'h40);
    rc(REG_RX_CFG, 8'h0d, 8'hff);
    wr(REG_LINK_CTL, 8'h00);
    rc(REG_LINK1_SLOT, 8'h00, 8'hff);
    rc(REG_RX_CFG, 8'h00, 8'hff);
    // receive bank of link 1: odd-frame sa8, then all of slot 20
    wr(REG_LINK1_SLOT, 8'h40);
    wr(REG_LINK1_MASK, 8'h01);
    wr(REG_RX_CFG, 8'h01);
    cyc(1030);
    wr(REG_LINK1_SLOT, 8'hd4);
    wr(REG_LINK1_MASK, 8'hff);
    cyc(1030);
    rc(REG_LINK1_MASK, 8'hff, 8'hff);
    rc(REG_RX_CFG, 8'h01, 8'hff);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    tReset();
    tRx();
    tTx();
    testDone();
  end
endmodule
